// ==== hdl/ssr_pkg.sv ====
// Purpose: constants for the secondary status readback bank
// Assumes: one byte per command code, codes are byte offsets
// Notes:   positions are bit indices within the selected byte
`default_nettype none
package ssr_pkg;
	localparam int unsigned DATA_W        = 8;
	localparam int unsigned CODE_W        = 8;
	localparam int unsigned WDT_W         = 10;
	localparam int unsigned WDT_FIELD_W   = 6;
	localparam int unsigned SLEEP_W       = 3;

	localparam logic [7:0] CMD_CAPABILITY = 8'h00;
	localparam logic [7:0] CMD_SLEEP      = 8'h01;
	localparam logic [7:0] CMD_RESERVED   = 8'h02;
	localparam logic [7:0] CMD_WATCHDOG   = 8'h03;
	localparam logic [7:0] CMD_EVENT      = 8'h04;
	localparam logic [7:0] CMD_PLATFORM   = 8'h05;

	localparam logic [7:0] CAPABILITY_VAL = 8'h00;
	localparam logic [7:0] ZERO_BYTE      = 8'h00;
	localparam logic [5:0] WDT_SAT_VAL    = 6'h3f;
	localparam logic [9:0] WDT_SAT_LIMIT  = 10'h03f;

	localparam logic [2:0] SLEEP_S0       = 3'h0;
	localparam logic [2:0] SLEEP_S3       = 3'h3;
	localparam logic [2:0] SLEEP_S4       = 3'h4;
	localparam logic [2:0] SLEEP_S5       = 3'h5;

	localparam int unsigned EV_INTRUSION  = 0;
	localparam int unsigned EV_THERMAL    = 1;
	localparam int unsigned EV_DEAD       = 2;
	localparam int unsigned EV_SECOND_TO  = 3;
	localparam int unsigned EV_FW_BLANK   = 7;

	localparam int unsigned PL_ALERT      = 0;
	localparam int unsigned PL_BATT_LOW   = 1;
	localparam int unsigned PL_PWR_FAIL   = 2;

	localparam logic [7:0] FW_BLANK_DATA  = 8'hff;
	localparam logic       ALERT_FORCED   = 1'b1;
endpackage
`default_nettype wire

// ==== hdl/ssr_wdt_sat.sv ====
// Purpose: saturating snapshot of the watchdog count into a narrow field
// Assumes: count is synchronous to clk
// Notes:   one cycle of latency from count to field
`default_nettype none
module ssr_wdt_sat #(
	parameter int unsigned IN_W  = 10,
	parameter int unsigned OUT_W = 6
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic [IN_W-1:0]  count,
	output logic      [OUT_W-1:0] field
);
	import ssr_pkg::*;

	typedef struct packed {
		logic [OUT_W-1:0] field;
	} ssr_sat_s;

	localparam logic [IN_W-1:0] LIMIT = IN_W'((1 << OUT_W) - 1);

	ssr_sat_s st_ff;
	ssr_sat_s nxt_st;

	always_comb begin
		nxt_st = st_ff;
		// clamp instead of dropping upper bits
		if (count > LIMIT) begin // RQ6
			nxt_st.field = {OUT_W{1'b1}};
		end else begin
			nxt_st.field = count[OUT_W-1:0]; // RQ5
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign field = st_ff.field;

	property p_sat_high;
		@(posedge clk) disable iff (!rstn)
		(count > LIMIT) |=> (field == {OUT_W{1'b1}});
	endproperty
	a_sat_high: assert property (p_sat_high) // RQ6
		else $error("watchdog field not saturated");

	property p_sat_pass;
		@(posedge clk) disable iff (!rstn)
		(count <= LIMIT) |=> (field == $past(count[OUT_W-1:0]));
	endproperty
	a_sat_pass: assert property (p_sat_pass) // RQ5
		else $error("watchdog field not equal to count");
endmodule
`default_nettype wire

// ==== hdl/ssr_readback.sv ====
// Purpose: status bytes returned to the external primary by command code
// Assumes: framing logic pulses cmd_valid with the received command code
// Notes:   answer is registered and marked by rd_valid one cycle later
//
// What this block does
// (RQ1) Primary reads each byte by byte-read; command code selects the byte.
// (RQ2) Command code zero returns capabilities byte of zero.
// (RQ3) Byte one bits 2:0 carry sleep state S0, S3, S4, S5.
// (RQ4) Byte one bits 7:3 and all of byte two are reserved.
// (RQ5) Byte three bits 5:0 carry the watchdog count, which is 10 bits.
// (RQ6) Watchdog counts above 3Fh read as 3Fh, never truncated.
// (RQ7) Watchdog byte bits 7:6 are reserved.
// (RQ8) Event byte bit 0 shows the intrusion flag.
// (RQ9) Event byte bit 1 is set while the thermal alarm is active.
// (RQ10) Event byte bit 2 reports the processor considered dead.
// (RQ11) Event byte bit 3 mirrors the second watchdog timeout flag.
// (RQ12) Event byte bits 6:4 always read zero; readers ignore them.
// (RQ13) Alert bit shows pin level when enabled and the pin is in alert function; reads one otherwise.
// (RQ14) Firmware-blank bit is one when firmware memory read gave FFh.
// (RQ15) Platform byte bit 1 is one while battery low input is low.
// (RQ16) Platform byte bit 2 is one while power failure flag is set.
// (RQ17) Reserved bits and unimplemented command codes read as zero.
`default_nettype none
module ssr_readback #(
	parameter int unsigned WDT_W = ssr_pkg::WDT_W
) (
	input  wire logic                           clk,
	input  wire logic                           rstn,
	input  wire logic                           cmd_valid,
	input  wire logic [ssr_pkg::CODE_W-1:0]     cmd_code,
	output logic      [ssr_pkg::DATA_W-1:0]     rd_data,
	output logic                                rd_valid,
	input  wire logic [ssr_pkg::SLEEP_W-1:0]    sleep_state,
	input  wire logic [WDT_W-1:0]               watchdog_count,
	input  wire logic                           intrusion_flag,
	input  wire logic                           thermal_alarm_input_n,
	input  wire logic                           processor_dead,
	input  wire logic                           watchdog_second_timeout,
	input  wire logic                           alert_capable_pin,
	input  wire logic                           alert_pin_is_alert,
	input  wire logic                           alert_disable,
	input  wire logic                           firmware_memory_done,
	input  wire logic [ssr_pkg::DATA_W-1:0]     firmware_memory_data,
	input  wire logic                           battery_low_input_n,
	input  wire logic                           power_failure_flag
);
	import ssr_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0] rd_data;
		logic              rd_valid;
		logic              fw_blank;
	} ssr_state_s;

	ssr_state_s                 st_ff;
	ssr_state_s                 nxt_st;
	logic [WDT_FIELD_W-1:0]     wdt_field;
	logic [DATA_W-1:0]          sleep_byte;
	logic [DATA_W-1:0]          wdt_byte;
	logic [DATA_W-1:0]          event_byte;
	logic [DATA_W-1:0]          platform_byte;
	logic                       alert_bit;

	ssr_wdt_sat #(
		.IN_W  (WDT_W),
		.OUT_W (WDT_FIELD_W)
	) u_wdt_sat (
		.clk   (clk),
		.rstn  (rstn),
		.count (watchdog_count),
		.field (wdt_field)
	);

	always_comb begin
		sleep_byte = ZERO_BYTE;
		sleep_byte[SLEEP_W-1:0] = sleep_state; // RQ3 RQ4

		wdt_byte = ZERO_BYTE;
		wdt_byte[WDT_FIELD_W-1:0] = wdt_field; // RQ5 RQ7

		event_byte = ZERO_BYTE; // RQ12
		event_byte[EV_INTRUSION] = intrusion_flag; // RQ8
		event_byte[EV_THERMAL]   = ~thermal_alarm_input_n; // RQ9
		event_byte[EV_DEAD]      = processor_dead; // RQ10
		event_byte[EV_SECOND_TO] = watchdog_second_timeout; // RQ11
		event_byte[EV_FW_BLANK]  = st_ff.fw_blank; // RQ14

		// pin level only meaningful in alert function; idle high otherwise
		if (alert_disable) begin // RQ13
			alert_bit = ALERT_FORCED;
		end else if (alert_pin_is_alert) begin
			alert_bit = alert_capable_pin;
		end else begin
			alert_bit = ALERT_FORCED;
		end

		platform_byte = ZERO_BYTE; // RQ17
		platform_byte[PL_ALERT]    = alert_bit; // RQ13
		platform_byte[PL_BATT_LOW] = ~battery_low_input_n; // RQ15
		platform_byte[PL_PWR_FAIL] = power_failure_flag; // RQ16
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.rd_valid = cmd_valid;
		// last completed firmware read decides the blank indication
		if (firmware_memory_done) begin // RQ14
			nxt_st.fw_blank = (firmware_memory_data == FW_BLANK_DATA);
		end
		if (cmd_valid) begin // RQ1
			if (cmd_code == CMD_CAPABILITY) begin
				nxt_st.rd_data = CAPABILITY_VAL; // RQ2
			end else if (cmd_code == CMD_SLEEP) begin
				nxt_st.rd_data = sleep_byte; // RQ3
			end else if (cmd_code == CMD_RESERVED) begin
				nxt_st.rd_data = ZERO_BYTE; // RQ4
			end else if (cmd_code == CMD_WATCHDOG) begin
				nxt_st.rd_data = wdt_byte; // RQ5
			end else if (cmd_code == CMD_EVENT) begin
				nxt_st.rd_data = event_byte;
			end else if (cmd_code == CMD_PLATFORM) begin
				nxt_st.rd_data = platform_byte;
			end else begin
				nxt_st.rd_data = ZERO_BYTE; // RQ17
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rd_data  = st_ff.rd_data;
	assign rd_valid = st_ff.rd_valid;

	property p_answer_timing;
		@(posedge clk) disable iff (!rstn)
		cmd_valid |=> rd_valid ##1 (rd_valid == $past(cmd_valid));
	endproperty
	a_answer_timing: assert property (p_answer_timing) // RQ1
		else $error("answer not one cycle after command");

	property p_capability;
		@(posedge clk) disable iff (!rstn)
		(cmd_valid && cmd_code == CMD_CAPABILITY) |=> (rd_data == ZERO_BYTE);
	endproperty
	a_capability: assert property (p_capability) // RQ2
		else $error("capability byte not zero");

	property p_sleep;
		@(posedge clk) disable iff (!rstn)
		(cmd_valid && cmd_code == CMD_SLEEP)
			|=> (rd_data == {5'h00, $past(sleep_state)});
	endproperty
	a_sleep: assert property (p_sleep) // RQ3
		else $error("sleep byte wrong");

	property p_reserved_byte;
		@(posedge clk) disable iff (!rstn)
		(cmd_valid && cmd_code == CMD_RESERVED) |=> (rd_data == ZERO_BYTE);
	endproperty
	a_reserved_byte: assert property (p_reserved_byte) // RQ4
		else $error("reserved byte not zero");

	property p_wdt_byte;
		@(posedge clk) disable iff (!rstn)
		(cmd_valid && cmd_code == CMD_WATCHDOG)
			|=> (rd_data == {2'h0, $past(wdt_field)});
	endproperty
	a_wdt_byte: assert property (p_wdt_byte) // RQ7
		else $error("watchdog byte wrong");

	property p_event;
		@(posedge clk) disable iff (!rstn)
		(cmd_valid && cmd_code == CMD_EVENT) |=>
			(rd_data[3:0] == $past({watchdog_second_timeout,
			processor_dead, ~thermal_alarm_input_n, intrusion_flag}))
			&& (rd_data[6:4] == 3'h0);
	endproperty
	a_event: assert property (p_event) // RQ12
		else $error("event byte wrong");

	property p_alert_disabled;
		@(posedge clk) disable iff (!rstn)
		(cmd_valid && cmd_code == CMD_PLATFORM && alert_disable)
			|=> rd_data[PL_ALERT];
	endproperty
	a_alert_disabled: assert property (p_alert_disabled) // RQ13
		else $error("alert bit not forced high");

	property p_platform;
		@(posedge clk) disable iff (!rstn)
		(cmd_valid && cmd_code == CMD_PLATFORM) |=>
			(rd_data[2:1] == $past({power_failure_flag,
			~battery_low_input_n})) && (rd_data[7:3] == 5'h00);
	endproperty
	a_platform: assert property (p_platform) // RQ15
		else $error("platform byte wrong");

	property p_fw_blank;
		@(posedge clk) disable iff (!rstn)
		(firmware_memory_done && firmware_memory_data == FW_BLANK_DATA)
			##1 (cmd_valid && cmd_code == CMD_EVENT && !firmware_memory_done)
			|=> rd_data[EV_FW_BLANK];
	endproperty
	a_fw_blank: assert property (p_fw_blank) // RQ14
		else $error("firmware blank bit not set");

	property p_unmapped;
		@(posedge clk) disable iff (!rstn)
		(cmd_valid && cmd_code > CMD_PLATFORM) |=> (rd_data == ZERO_BYTE);
	endproperty
	a_unmapped: assert property (p_unmapped) // RQ17
		else $error("unmapped code not zero");
endmodule
`default_nettype wire

// ==== sim/ssr_primary.sv ====
// Purpose: external primary that issues byte-read command codes
// Assumes: the bench raises req for one cycle per byte read
// Notes:   idle code lines show the inverse of the last code sent
`default_nettype none
module ssr_primary (
	input  wire logic       clk,
	input  wire logic       req,
	input  wire logic [7:0] req_code,
	output logic            cmd_valid,
	output logic      [7:0] cmd_code
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] last_ff = 8'h00;
	// remember the code taken at the edge, away from the bench's drive edge
	always @(posedge clk) begin
		if (req)
			last_ff <= req_code;
	end
	// one code per byte read, released lines never keep the old code
	assign cmd_valid = req;
	assign cmd_code  = req ? req_code : ~last_ff;
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Purpose: random byte reads checked against a behavioural model
// Assumes: inputs change at the falling edge, answers one cycle later
// Notes:   watchdog field uses the count seen one edge before the read
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ssr_pkg::*;
	logic       clk = 1'b0;
	logic       rstn = 1'b0;
	logic       req = 1'b0;
	logic [7:0] req_code = 8'h00;
	logic [7:0] fw_data = 8'h00;
	logic [2:0] sleep = 3'h0;
	logic [9:0] wdt = 10'h000;
	logic [9:0] flg = 10'h000;
	logic       cmd_valid;
	logic [7:0] cmd_code;
	logic [7:0] rd_data;
	logic       rd_valid;
	logic [15:0] lf = 16'h0040;
	logic [2:0] enc [4] = '{SLEEP_S0, SLEEP_S3, SLEEP_S4, SLEEP_S5};
	logic [5:0] sat_q = 6'h00;
	logic       blank_q = 1'b0;
	logic       due_q = 1'b0;
	logic [7:0] exp_q = 8'h00;
	int         n_fail = 0;
	int         comparisons = 0;

	ssr_primary i_pri (.clk(clk), .req(req), .req_code(req_code),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code));
	ssr_readback i_dut (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .rd_data(rd_data), .rd_valid(rd_valid),
		.sleep_state(sleep), .watchdog_count(wdt),
		.intrusion_flag(flg[0]), .thermal_alarm_input_n(flg[1]),
		.processor_dead(flg[2]), .watchdog_second_timeout(flg[3]),
		.alert_capable_pin(flg[4]), .alert_pin_is_alert(flg[5]),
		.alert_disable(flg[6]), .firmware_memory_done(flg[7]),
		.firmware_memory_data(fw_data), .battery_low_input_n(flg[8]),
		.power_failure_flag(flg[9]));

	initial begin
		forever #5 clk = ~clk;
	end

	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	function automatic logic [7:0] model(input logic [7:0] c);
		logic al;
		al = flg[6] | ~flg[5] | flg[4];
		case (c)
		8'h01: return {5'h00, sleep};
		8'h03: return {2'h0, sat_q};
		8'h04: return {blank_q, 3'h0, flg[3:2], ~flg[1], flg[0]};
		8'h05: return {5'h00, flg[9], ~flg[8], al};
		default: return 8'h00;
		endcase
	endfunction

	task automatic chk(input string what, input logic [7:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		if (n_fail == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// answer launched at this edge, built before snapshot and blank move on
	always @(posedge clk) begin
		due_q = rstn & cmd_valid;
		if (!rstn)
			exp_q = 8'h00;
		else if (due_q)
			exp_q = model(cmd_code);
		sat_q = !rstn ? 6'h00 : (wdt > 10'h03f ? 6'h3f : wdt[5:0]);
		if (!rstn)
			blank_q = 1'b0;
		else if (flg[7])
			blank_q = (fw_data == FW_BLANK_DATA);
	end

	always @(negedge clk) begin
		chk("rd_valid", {7'h00, rd_valid}, {7'h00, due_q});
		chk("rd_data", rd_data, exp_q);
	end

	initial begin
		fork
			begin
				#20000;
				n_fail++;
				conclude();
			end
		join_none
		repeat (8) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		chk("rd_data", rd_data, ZERO_BYTE);
		for (int i = 0; i < 1200; i++) begin
			lf = nxt(lf);
			flg = lf[9:0];
			sleep = enc[lf[15:14]];
			lf = nxt(lf);
			wdt = lf[15] ? lf[9:0] : 10'h03e + {8'h00, lf[1:0]};
			fw_data = lf[13] ? FW_BLANK_DATA : lf[7:0];
			req = lf[12] | lf[11];
			req_code = lf[10] ? lf[7:0] : {5'h00, lf[2:0]};
			@(negedge clk);
		end
		req = 1'b0;
		repeat (3) @(negedge clk);
		conclude();
	end
endmodule
`default_nettype wire
